// ### verilog/ppmrc_params.svh
`ifndef PPMRC_PARAMS_SVH
`define PPMRC_PARAMS_SVH
`define PPMRC_IDX_MODE 8'h12
`define PPMRC_IDX_PHASE 8'h14
`define PPMRC_IDX_BACKOFF 8'h15
`define PPMRC_IDX_PWRCMD 8'h19
`define PPMRC_IDX_RSTCMD 8'h1a
`define PPMRC_IDX_BYPASS 8'h23
`define PPMRC_IDX_STATUS 8'h30
`define PPMRC_IDX_EVENT 8'h31
`define PPMRC_MODE_AUTO 2'b11
`define PPMRC_MODE_SEMI 2'b10
`define PPMRC_MODE_MAN 2'b01
`define PPMRC_MODE_SHUT 2'b00
`define PPMRC_MODE_RST 2'b11
`define PPMRC_BIT_DETEN 0
`define PPMRC_BIT_CLSEN 4
`define PPMRC_BIT_BACKOFF 0
`define PPMRC_BIT_PWRON 0
`define PPMRC_BIT_PWROFF 4
`define PPMRC_BIT_PORTRST 0
`define PPMRC_BIT_CHIPRST 4
`define PPMRC_BIT_BYPASS 4
`define PPMRC_EV_DET 0
`define PPMRC_EV_CLS 1
`define PPMRC_EV_FAULT 2
`define PPMRC_CLK_MHZ 20
`define PPMRC_EN_LOW_US 40
`define PPMRC_CADENCE_MIN_MS 2000
`define PPMRC_EN_LOW_CYC (`PPMRC_EN_LOW_US * `PPMRC_CLK_MHZ)
`define PPMRC_CADENCE_CYC (`PPMRC_CADENCE_MIN_MS * 1000 * `PPMRC_CLK_MHZ)
`endif

// ### verilog/ppmrc_pkg.sv
package ppmrc_pkg;
  typedef struct packed {
    logic cadence;
    logic highCap;
    logic acDisconnect;
  } ppmrc_straps_t;
  typedef struct packed {
    logic detDone;
    logic detValid;
    logic clsDone;
    logic clsValid;
    logic fault;
  } ppmrc_afe_t;
  typedef enum logic [4:0] {
    PS_IDLE = 5'b00001,
    PS_DETECT = 5'b00010,
    PS_CLASSIFY = 5'b00100,
    PS_POWERED = 5'b01000,
    PS_BACKOFF = 5'b10000
  } ppmrc_state_t;
endpackage

// ### verilog/ppmrc_top.sv
// Operation
// [R01] Hold device in reset until supply lockout indication clears.
// [R02] Enable pin low longer than 40 us resets the device.
// [R03] Hardware reset ends when enable pin returns high.
// [R04] Chip soft-reset bit resets everything, self-clears, registers return to defaults.
// [R05] Over-temperature holds device in reset; clearing gives full reset release.
// [R06] Straps sampled at reset end; later changes ignored.
// [R07] Host changes AC-disconnect strap only while device is in reset.
// [R08] Port reset bit turns off power, clears port events and status only.
// [R09] With cadence enabled wait 2 s to 2.4 s after failed detection.
// [R10] Cadence enabled by latched strap or software backoff bit.
// [R11] Switching among auto, semi and manual keeps port output state.
// [R12] Shutdown stops port at once; idle until another mode selected.
// [R13] Auto mode after reset; mode field 11 selects auto.
// [R14] Auto mode detects, classifies, powers valid load, else repeats detection.
// [R15] Entering auto sets detect and classify enables; cleared bit skips phase.
// [R16] Auto with detection disabled powers only if bypass bit set.
// [R17] Mode 10 is semi: repeats requested phases, never powers itself.
// [R18] Power-on command aborts detection or classification and powers port.
// [R19] Semi mode clears enables by default; host sets them to run.
// [R20] Semi enables cleared only by reset or power-off command.
// [R21] Mode 01 is manual; both enables run detection then classification.
// [R22] Mode 00 is shutdown: power off, clear events, ignore commands.
// [R23] Manual enables are one-shot; cleared when their cycle ends.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ppmrc_params.svh"
module ppmrc_top
  import ppmrc_pkg::*;
#(
  parameter int EN_LOW_CYCLES = `PPMRC_EN_LOW_CYC,
  parameter int BACKOFF_CYCLES = `PPMRC_CADENCE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supplyLockout,
  input wire logic enablePin,
  input wire logic overTemp,
  input wire ppmrc_straps_t straps,
  input wire ppmrc_afe_t afe,
  output logic deviceReset,
  output ppmrc_straps_t strapsHeld,
  output logic cadenceOn,
  output logic detectRun,
  output logic classifyRun,
  output logic portPower
);
  logic coreReset;
  logic softResetReq;
  logic [31:0] enLowCount;
  logic [31:0] backoffCount;
  logic [1:0] mode;
  logic detEn;
  logic clsEn;
  logic backoffBit;
  logic bypassBit;
  logic detPassed;
  logic [2:0] events;
  ppmrc_state_t state;
  ppmrc_state_t next_state;

  wire [7:0] regIdx = paddr[9:2];
  wire access = psel && penable;
  wire wrEn = access && pready && pwrite;
  wire rdTake = access && !pready && !pwrite;
  wire selMode = regIdx == `PPMRC_IDX_MODE;
  wire selPhase = regIdx == `PPMRC_IDX_PHASE;
  wire selBackoff = regIdx == `PPMRC_IDX_BACKOFF;
  wire selPwr = regIdx == `PPMRC_IDX_PWRCMD;
  wire selRst = regIdx == `PPMRC_IDX_RSTCMD;
  wire selBypass = regIdx == `PPMRC_IDX_BYPASS;
  wire selStatus = regIdx == `PPMRC_IDX_STATUS;
  wire selEvent = regIdx == `PPMRC_IDX_EVENT;
  wire mapped = selMode | selPhase | selBackoff | selPwr | selRst | selBypass | selStatus | selEvent;
  wire wMode = wrEn && selMode;
  wire wPhase = wrEn && selPhase;
  wire wPwr = wrEn && selPwr;
  wire wRst = wrEn && selRst;
  wire shutMode = mode == `PPMRC_MODE_SHUT;
  wire autoMode = mode == `PPMRC_MODE_AUTO;
  wire semiMode = mode == `PPMRC_MODE_SEMI;
  wire manMode = mode == `PPMRC_MODE_MAN;
  wire [1:0] newMode = pwdata[1:0];
  wire modeChange = wMode && (newMode != mode);
  // Power-on commands are refused outright while shut down.
  wire pwrOnCmd = wPwr && pwdata[`PPMRC_BIT_PWRON] && !shutMode; // [R18] [R22]
  wire pwrOffCmd = wPwr && pwdata[`PPMRC_BIT_PWROFF];
  wire portReset = wRst && pwdata[`PPMRC_BIT_PORTRST]; // [R08]
  wire chipReset = wRst && pwdata[`PPMRC_BIT_CHIPRST]; // [R04]
  wire enLowLong = enLowCount >= EN_LOW_CYCLES; // [R02]
  wire anyReset = supplyLockout || enLowLong || overTemp || softResetReq; // [R01] [R05]
  wire cadenceEn = strapsHeld.cadence || backoffBit; // [R10]
  wire backoffDone = backoffCount >= BACKOFF_CYCLES;
  wire detEnd = (state == PS_DETECT) && afe.detDone;
  wire clsEnd = (state == PS_CLASSIFY) && afe.clsDone;
  // Shutdown entry and port reset both drop the port and its events at once.
  wire portKill = portReset || (wMode && newMode == `PPMRC_MODE_SHUT) || shutMode; // [R12] [R22]
  wire detPass = detEnd && afe.detValid;
  wire mayPower = autoMode && (detPassed || detPass || bypassBit) && !portKill; // [R16] [R17]

  // The enable pin must stay low the whole window; a short glitch restarts the count.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enLowCount <= 32'h00000000;
    end else if (enablePin) begin
      enLowCount <= 32'h00000000; // [R03]
    end else if (!enLowLong) begin
      enLowCount <= enLowCount + 32'h00000001; // [R02]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coreReset <= 1'b1;
      softResetReq <= 1'b0;
    end else begin
      coreReset <= anyReset; // [R01] [R03] [R05]
      softResetReq <= chipReset && !coreReset; // [R04]
    end
  end

  // Straps follow the pins throughout reset, so the value held is the one at release.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strapsHeld <= '0;
    end else if (coreReset) begin
      strapsHeld <= straps; // [R06] [R07]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= `PPMRC_MODE_RST;
      backoffBit <= 1'b0;
      bypassBit <= 1'b0;
    end else if (coreReset) begin
      mode <= `PPMRC_MODE_RST; // [R13]
      backoffBit <= 1'b0;
      bypassBit <= 1'b0;
    end else begin
      if (wMode) begin
        mode <= newMode; // [R11] [R13] [R17] [R21] [R22]
      end
      if (wrEn && selBackoff) begin
        backoffBit <= pwdata[`PPMRC_BIT_BACKOFF]; // [R10]
      end
      if (wrEn && selBypass) begin
        bypassBit <= pwdata[`PPMRC_BIT_BYPASS]; // [R16]
      end
    end
  end

  // Phase enables: configuration bits in auto and semi, one-shot pushbuttons in manual.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      detEn <= 1'b1;
      clsEn <= 1'b1;
    end else if (coreReset) begin
      detEn <= 1'b1; // [R15]
      clsEn <= 1'b1;
    end else if (modeChange) begin
      detEn <= newMode == `PPMRC_MODE_AUTO; // [R15] [R19] [R23]
      clsEn <= newMode == `PPMRC_MODE_AUTO;
    end else if (pwrOffCmd && semiMode) begin
      detEn <= 1'b0; // [R20]
      clsEn <= 1'b0;
    end else if (wPhase) begin
      detEn <= pwdata[`PPMRC_BIT_DETEN]; // [R19]
      clsEn <= pwdata[`PPMRC_BIT_CLSEN];
    end else begin
      if (manMode && (detEnd || pwrOnCmd)) begin
        detEn <= 1'b0; // [R23]
      end
      if (manMode && (clsEnd || pwrOnCmd)) begin
        clsEn <= 1'b0; // [R23]
      end
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      PS_IDLE: begin
        if (detEn) begin
          next_state = PS_DETECT; // [R14]
        end else if (clsEn) begin
          next_state = PS_CLASSIFY; // [R15]
        end else if (mayPower) begin
          next_state = PS_POWERED; // [R16]
        end
      end
      PS_DETECT: begin
        if (detPass && clsEn) begin
          next_state = PS_CLASSIFY; // [R21]
        end else if (detPass && mayPower) begin
          next_state = PS_POWERED; // [R14]
        end else if (detEnd && !afe.detValid && cadenceEn) begin
          next_state = PS_BACKOFF; // [R09]
        end else if (detEnd) begin
          next_state = PS_IDLE; // [R14] [R17]
        end
      end
      PS_CLASSIFY: begin
        if (clsEnd && afe.clsValid && mayPower) begin
          next_state = PS_POWERED; // [R14]
        end else if (clsEnd) begin
          next_state = PS_IDLE; // [R17]
        end
      end
      PS_POWERED: begin
        if (afe.fault) begin
          next_state = PS_IDLE; // [R20]
        end
      end
      PS_BACKOFF: begin
        if (backoffDone) begin
          next_state = PS_IDLE; // [R09]
        end
      end
    endcase
    if (pwrOnCmd) begin
      next_state = PS_POWERED; // [R18]
    end
    if (pwrOffCmd || portKill) begin
      next_state = PS_IDLE; // [R08] [R12] [R22]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= PS_IDLE;
      detPassed <= 1'b0;
    end else if (coreReset) begin
      state <= PS_IDLE;
      detPassed <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state == PS_IDLE || next_state == PS_POWERED) begin
        detPassed <= 1'b0;
      end else if (detPass) begin
        detPassed <= 1'b1;
      end
    end
  end

  // The backoff count restarts on entry so every failed detection gets the full wait.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      backoffCount <= 32'h00000000;
    end else if (state != PS_BACKOFF) begin
      backoffCount <= 32'h00000000;
    end else if (!backoffDone) begin
      backoffCount <= backoffCount + 32'h00000001; // [R09]
    end
  end

  // Events are sticky; a new event wins over a same-cycle write-one-to-clear.
  wire [2:0] evSet = {state == PS_POWERED && afe.fault, clsEnd, detEnd};
  wire [2:0] evClr = (wrEn && selEvent) ? pwdata[2:0] : 3'b000;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      events <= 3'b000;
    end else if (coreReset || portKill) begin
      events <= 3'b000; // [R08] [R22]
    end else begin
      events <= (events & ~evClr) | evSet;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      deviceReset <= 1'b1;
      cadenceOn <= 1'b0;
      detectRun <= 1'b0;
      classifyRun <= 1'b0;
      portPower <= 1'b0;
    end else begin
      deviceReset <= coreReset;
      cadenceOn <= cadenceEn && !coreReset;
      detectRun <= !coreReset && next_state == PS_DETECT;
      classifyRun <= !coreReset && next_state == PS_CLASSIFY;
      portPower <= !coreReset && next_state == PS_POWERED; // [R11] [R18]
    end
  end

  wire [31:0] statusWord = {22'h0, cadenceEn, strapsHeld, portPower, state};
  wire [31:0] rdMux = selMode ? {30'h0, mode} :
                      selPhase ? {27'h0, clsEn, 3'h0, detEn} :
                      selBackoff ? {31'h0, backoffBit} :
                      selBypass ? {27'h0, bypassBit, 4'h0} :
                      selStatus ? statusWord :
                      selEvent ? {29'h0, events} : 32'h00000000;

  // One wait state: pready rises in the second access cycle, read data lands with it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !mapped;
      if (rdTake) begin
        prdata <= rdMux;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/ppmrc_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppmrc_afe_model
  import ppmrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic detectRun,
  input wire logic classifyRun,
  input wire logic loadOk,
  input wire logic faultReq,
  output ppmrc_afe_t afe
);
  logic [2:0] age;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      age <= 3'h0;
    end else begin
      age <= ((detectRun || classifyRun) && age != 3'h4) ? age + 3'h1 : 3'h0;
    end
  end
  // Each measurement answers three cycles into its phase, four for classification straight after detection.
  assign afe.detDone = detectRun && age == 3'h3;
  assign afe.clsDone = classifyRun && age == 3'h3;
  // Valid lines carry junk when no result is due, so a design that samples them early sees noise.
  assign afe.detValid = afe.detDone ? loadOk : age[0];
  assign afe.clsValid = afe.clsDone ? loadOk : age[0];
  assign afe.fault = faultReq;
endmodule
`default_nettype wire

// ### tb/ppmrc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppmrc_params.svh"
module ppmrc_monitor
  import ppmrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic supplyLockout,
  input wire logic enablePin,
  input wire logic overTemp,
  input wire ppmrc_straps_t straps,
  input wire ppmrc_afe_t afe,
  input wire logic deviceReset,
  input wire ppmrc_straps_t strapsHeld,
  input wire logic cadenceOn,
  input wire logic detectRun,
  input wire logic classifyRun,
  input wire logic portPower
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic rstWr;
  assign rstWr = psel && penable && pready && pwrite && paddr[9:2] == `PPMRC_IDX_RSTCMD;
  // The registered cadence flag one cycle after the failed result is the enable the state machine acted on.
  sequence s_failDet;
    (detectRun && afe.detDone && !afe.detValid) ##1 cadenceOn;
  endsequence
  sequence s_quiet;
    (!detectRun) [*8];
  endsequence
  a_lockout_holds: assert property (supplyLockout |=> ##1 deviceReset) else $error("lockout ignored");
  a_enable_long: assert property ((!enablePin) [*8] |-> ##[1:3] deviceReset) else $error("enable low ignored");
  a_heat_reset: assert property (overTemp |=> ##1 deviceReset) else $error("overtemp ignored");
  a_reset_unpowered: assert property (deviceReset |-> !portPower) else $error("power in reset");
  a_straps_frozen: assert property (!deviceReset && !$past(deviceReset) |-> $stable(strapsHeld))
    else $error("straps moved");
  a_cadence_strap: assert property (!deviceReset && !$past(deviceReset) && strapsHeld.cadence |-> cadenceOn)
    else $error("cadence strap lost");
  a_backoff_wait: assert property (s_failDet |-> s_quiet ##1 s_quiet ##1 (!detectRun) [*4] ##[1:8] detectRun)
    else $error("backoff wrong");
  a_port_off: assert property (rstWr && pwdata[0] |=> ##[0:2] !portPower) else $error("port reset kept power");
  a_port_local: assert property (rstWr && pwdata[0] && !pwdata[4] && !deviceReset |=> (!deviceReset) [*4])
    else $error("port reset went global");
  a_chip_reset: assert property (rstWr && pwdata[4] |-> ##[2:5] deviceReset) else $error("soft reset missed");
endmodule
bind ppmrc_top ppmrc_monitor i_ppmrc_monitor (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .supplyLockout(supplyLockout), .enablePin(enablePin), .overTemp(overTemp), .straps(straps), .afe(afe),
  .deviceReset(deviceReset), .strapsHeld(strapsHeld), .cadenceOn(cadenceOn), .detectRun(detectRun),
  .classifyRun(classifyRun), .portPower(portPower));
`default_nettype wire

// ### tb/poe_port_mode_reset_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module poe_port_mode_reset_control_bench
  import ppmrc_pkg::*;
;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic supplyLockout = 1, enablePin = 1, overTemp = 0, loadOk = 1, faultReq = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, v;
  logic pready, pslverr, deviceReset, cadenceOn, detectRun, classifyRun, portPower, bad;
  ppmrc_straps_t straps = 3'b011, strapsHeld;
  ppmrc_afe_t afe;
  int err_total = 0, samples_checked = 0;
  initial forever #25 clk = ~clk;
  ppmrc_top #(.EN_LOW_CYCLES(8), .BACKOFF_CYCLES(20)) i_ppmrc_top (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .supplyLockout(supplyLockout), .enablePin(enablePin), .overTemp(overTemp),
    .straps(straps), .afe(afe), .deviceReset(deviceReset), .strapsHeld(strapsHeld), .cadenceOn(cadenceOn),
    .detectRun(detectRun), .classifyRun(classifyRun), .portPower(portPower));
  ppmrc_afe_model i_ppmrc_afe_model (.clk(clk), .rst(rst), .detectRun(detectRun),
    .classifyRun(classifyRun), .loadOk(loadOk), .faultReq(faultReq), .afe(afe));
  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    v = prdata;
    bad = pslverr;
    psel <= 0;
    penable <= 0;
    check(n < 20, 1);
  endtask
  task rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(0, idx, 0);
    check(v, exp);
  endtask
  function automatic logic sig(input int s);
    return s == 0 ? portPower : s == 1 ? deviceReset : s == 2 ? detectRun : classifyRun;
  endfunction
  // Outputs are looked at on the falling edge, well clear of the flops' updates.
  task waitSig(input int s, input logic val);
    int n;
    n = 0;
    while (sig(s) !== val && n < 400) begin
      @(negedge clk);
      n++;
    end
    check(sig(s), val);
  endtask
  task idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task final_report;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #500000;
    err_total++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (4) @(posedge clk);
    check(deviceReset, 1);
    supplyLockout <= 0;
    waitSig(1, 0);
    rdchk(8'h12, 32'h3);
    rdchk(8'h14, 32'h11);
    check(strapsHeld, 3'b011);
    // Only the cadence strap moves here; the high-capacitance and AC-disconnect straps keep their levels.
    straps <= 3'b111;
    waitSig(0, 1);
    check(strapsHeld, 3'b011);
    apb(0, 8'h40, 0);
    check(bad, 1);
    apb(1, 8'h12, 32'h2);
    idle(4);
    check(portPower, 1);
    rdchk(8'h14, 32'h0);
    apb(1, 8'h19, 32'h10);
    waitSig(0, 0);
    apb(1, 8'h14, 32'h11);
    waitSig(3, 1);
    idle(60);
    check(portPower, 0);
    apb(1, 8'h19, 32'h1);
    waitSig(0, 1);
    check(detectRun | classifyRun, 0);
    @(posedge clk) faultReq <= 1;
    waitSig(0, 0);
    @(posedge clk) faultReq <= 0;
    rdchk(8'h14, 32'h11);
    apb(1, 8'h19, 32'h1);
    waitSig(0, 1);
    apb(1, 8'h1a, 32'h1);
    waitSig(0, 0);
    check(deviceReset, 0);
    rdchk(8'h31, 32'h0);
    apb(1, 8'h19, 32'h1);
    waitSig(0, 1);
    apb(1, 8'h19, 32'h10);
    waitSig(0, 0);
    rdchk(8'h14, 32'h0);
    apb(1, 8'h19, 32'h1);
    waitSig(0, 1);
    apb(1, 8'h12, 32'h0);
    waitSig(0, 0);
    rdchk(8'h31, 32'h0);
    apb(1, 8'h19, 32'h1);
    idle(20);
    check(portPower, 0);
    apb(1, 8'h12, 32'h1);
    rdchk(8'h14, 32'h0);
    apb(1, 8'h14, 32'h11);
    waitSig(2, 1);
    check(classifyRun, 0);
    waitSig(3, 1);
    waitSig(3, 0);
    rdchk(8'h14, 32'h0);
    loadOk <= 0;
    apb(1, 8'h15, 32'h1);
    apb(1, 8'h12, 32'h3);
    apb(0, 8'h30, 0);
    check(v[9], 1);
    waitSig(2, 1);
    idle(120);
    check(portPower, 0);
    // Cadence goes off and any backoff in flight ends before detection is disabled.
    apb(1, 8'h15, 32'h0);
    apb(0, 8'h30, 0);
    check(v[9], 0);
    idle(30);
    apb(1, 8'h14, 32'h0);
    idle(10);
    loadOk <= 1;
    idle(60);
    check(portPower, 0);
    apb(1, 8'h23, 32'h10);
    waitSig(0, 1);
    apb(1, 8'h1a, 32'h10);
    waitSig(1, 1);
    waitSig(1, 0);
    rdchk(8'h15, 32'h0);
    rdchk(8'h23, 32'h0);
    check(strapsHeld, 3'b111);
    check(cadenceOn, 1);
    @(posedge clk) enablePin <= 0;
    repeat (3) @(posedge clk);
    enablePin <= 1;
    idle(6);
    check(deviceReset, 0);
    @(posedge clk) enablePin <= 0;
    waitSig(1, 1);
    @(posedge clk) enablePin <= 1;
    waitSig(1, 0);
    @(posedge clk) overTemp <= 1;
    waitSig(1, 1);
    @(posedge clk) overTemp <= 0;
    waitSig(1, 0);
    final_report;
  end
endmodule
`default_nettype wire
